// ---- nor_decode.sv ----
`timescale 1ns/1ps
module nor_decode (
    // instruction word
    input wire logic [15:0] opcode,
    // decoded class
    output nor_pkg::nor_op_t op_kind
);
    always_comb
    begin
        op_kind = nor_pkg::NOR_OP_NONE;
        if (opcode[15:9] == nor_pkg::OP_OR_TO_ACC_IMM)
            op_kind = nor_pkg::NOR_OP_OR_ACC;
        else if (opcode[15:7] == nor_pkg::OP_OR_STORE_MEM)
            op_kind = nor_pkg::NOR_OP_OR_MEM;
        else if (opcode[15:8] == nor_pkg::OP_OR_STORE_IMM)
            op_kind = nor_pkg::NOR_OP_OR_WREG;
        else if (opcode[15:7] == nor_pkg::OP_ROT_LEFT)
            op_kind = nor_pkg::NOR_OP_ROT_L;
        else if (opcode[15:7] == nor_pkg::OP_ROT_RIGHT)
            op_kind = nor_pkg::NOR_OP_ROT_R;
        else if (opcode[15:3] == nor_pkg::OP_SUB_RETURN)
            op_kind = nor_pkg::NOR_OP_RET;
    end
endmodule

// ---- nor_exec.sv ----
`timescale 1ns/1ps
module nor_exec (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // instruction issue, one machine cycle each
    input wire logic exec_en,
    input wire logic [15:0] opcode,
    // operands
    input wire logic [3:0] mem_rd_data,
    input wire logic [3:0] wreg_rd_data,
    input wire logic [10:0] stack_top,
    // state
    output logic [3:0] acc_reg,
    output logic carry_flag,
    output logic zero_flag,
    output logic [10:0] pc_reg,
    // write-backs
    output logic mem_we,
    output logic [6:0] mem_addr,
    output logic [3:0] mem_wr_data,
    output logic wreg_we,
    output logic [3:0] wreg_addr,
    output logic [3:0] wreg_wr_data,
    output logic stack_pop
);
    nor_pkg::nor_op_t op_kind;
    logic [3:0] imm;
    logic [3:0] result_next;
    logic carry_next;
    logic writes_acc;
    logic writes_carry;
    logic stores_mem;
    logic stores_wreg;
    logic takes_return;

    nor_decode u_decode (
        .opcode(opcode),
        .op_kind(op_kind)
    );

    assign imm = opcode[7:4];

    // ============================================================
    // datapath
    always_comb
    begin
        result_next = acc_reg;
        carry_next = carry_flag;
        writes_acc = 1'h0;
        writes_carry = 1'h0;
        stores_mem = 1'h0;
        stores_wreg = 1'h0;
        takes_return = 1'h0;
        unique case (op_kind)
            nor_pkg::NOR_OP_OR_ACC:
            begin
                result_next = wreg_rd_data | imm;
                writes_acc = 1'h1;
            end
            nor_pkg::NOR_OP_OR_MEM:
            begin
                result_next = mem_rd_data | acc_reg;
                writes_acc = 1'h1;
                stores_mem = 1'h1;
            end
            nor_pkg::NOR_OP_OR_WREG:
            begin
                result_next = wreg_rd_data | imm;
                writes_acc = 1'h1;
                stores_wreg = 1'h1;
            end
            nor_pkg::NOR_OP_ROT_L:
            begin
                result_next = {mem_rd_data[2:0], carry_flag};
                carry_next = mem_rd_data[3];
                writes_acc = 1'h1;
                writes_carry = 1'h1;
                stores_mem = 1'h1;
            end
            nor_pkg::NOR_OP_ROT_R:
            begin
                result_next = {carry_flag, mem_rd_data[3:1]};
                carry_next = mem_rd_data[0];
                writes_acc = 1'h1;
                writes_carry = 1'h1;
                stores_mem = 1'h1;
            end
            nor_pkg::NOR_OP_RET: takes_return = 1'h1;
            nor_pkg::NOR_OP_NONE: writes_acc = 1'h0;
        endcase
    end

    // ============================================================
    // accumulator
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            acc_reg <= nor_pkg::ACC_RST;
        else if (exec_en && writes_acc)
            acc_reg <= result_next;
    end

    // ============================================================
    // zero flag
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            zero_flag <= 1'h0;
        else if (exec_en && writes_acc)
            zero_flag <= (result_next == 4'h0);
    end

    // ============================================================
    // carry flag, only rotates move it
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            carry_flag <= 1'h0;
        else if (exec_en && writes_carry)
            carry_flag <= carry_next;
    end

    // ============================================================
    // program counter
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            pc_reg <= nor_pkg::PC_RST;
        else if (exec_en && takes_return)
            pc_reg <= stack_top;
    end

    // ============================================================
    // memory write-back, address and data held between stores
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mem_we <= 1'h0;
            mem_addr <= 7'h00;
            mem_wr_data <= 4'h0;
        end
        else
        begin
            mem_we <= exec_en && stores_mem;
            if (exec_en && stores_mem)
            begin
                mem_addr <= opcode[6:0];
                mem_wr_data <= result_next;
            end
        end
    end

    // ============================================================
    // working register write-back
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wreg_we <= 1'h0;
            wreg_addr <= 4'h0;
            wreg_wr_data <= 4'h0;
        end
        else
        begin
            wreg_we <= exec_en && stores_wreg;
            if (exec_en && stores_wreg)
            begin
                wreg_addr <= opcode[3:0];
                wreg_wr_data <= result_next;
            end
        end
    end

    // ============================================================
    // stack pop pulse for the return stack
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            stack_pop <= 1'h0;
        else
            stack_pop <= exec_en && takes_return;
    end

    // ============================================================
    // checks
    a_zero_tracks: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        exec_en && writes_acc |=> zero_flag == (acc_reg == 4'h0))
        else $error("zero flag mismatch");
    a_or_acc_only: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        exec_en && op_kind == nor_pkg::NOR_OP_OR_ACC
        |=> acc_reg == ($past(wreg_rd_data) | $past(imm)) && !mem_we && !wreg_we)
        else $error("or to accumulator wrong");
    a_or_mem_store: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        exec_en && op_kind == nor_pkg::NOR_OP_OR_MEM
        |=> mem_we && mem_wr_data == acc_reg && !wreg_we
        && acc_reg == ($past(mem_rd_data) | $past(acc_reg)))
        else $error("memory or store wrong");
    a_or_wreg_store: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        exec_en && op_kind == nor_pkg::NOR_OP_OR_WREG
        |=> wreg_we && wreg_wr_data == acc_reg && !mem_we
        && acc_reg == ($past(wreg_rd_data) | $past(imm)))
        else $error("register or store wrong");
    a_or_keeps_carry: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        exec_en && (op_kind == nor_pkg::NOR_OP_OR_ACC || op_kind == nor_pkg::NOR_OP_OR_MEM
        || op_kind == nor_pkg::NOR_OP_OR_WREG) |=> $stable(carry_flag))
        else $error("or changed carry");
    a_rot_left: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        exec_en && op_kind == nor_pkg::NOR_OP_ROT_L
        |=> carry_flag == $past(mem_rd_data[3]) && acc_reg[0] == $past(carry_flag)
        && acc_reg[3:1] == $past(mem_rd_data[2:0]) && mem_we && mem_wr_data == acc_reg)
        else $error("rotate left wrong");
    a_rot_right: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        exec_en && op_kind == nor_pkg::NOR_OP_ROT_R
        |=> carry_flag == $past(mem_rd_data[0]) && acc_reg[3] == $past(carry_flag)
        && acc_reg[2:0] == $past(mem_rd_data[3:1]) && mem_we && mem_wr_data == acc_reg)
        else $error("rotate right wrong");
    a_mem_addr: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        exec_en && stores_mem |=> mem_addr == $past(opcode[6:0]))
        else $error("memory address wrong");
    a_wreg_addr: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        exec_en && stores_wreg |=> wreg_addr == $past(opcode[3:0]))
        else $error("register address wrong");
    a_return_pc: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        exec_en && op_kind == nor_pkg::NOR_OP_RET
        |=> pc_reg == $past(stack_top) && stack_pop && $stable(acc_reg)
        && $stable(zero_flag) && $stable(carry_flag) && !mem_we && !wreg_we)
        else $error("return pc wrong");
    a_undecoded_quiet: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        exec_en && op_kind == nor_pkg::NOR_OP_NONE
        |=> $stable(acc_reg) && $stable(zero_flag) && $stable(carry_flag)
        && $stable(pc_reg) && !mem_we && !wreg_we && !stack_pop)
        else $error("undecoded op changed state");
    a_idle_quiet: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !exec_en |=> !mem_we && !wreg_we && !stack_pop && $stable(carry_flag)
        && $stable(acc_reg) && $stable(pc_reg))
        else $error("idle cycle changed state");
endmodule

// ---- nor_exec_tb_top.sv ----
`timescale 1ns/1ps
module nor_exec_tb_top;
    logic sys_clk;
    logic rst_n;
    logic exec_en;
    logic [15:0] opcode;
    logic [3:0] mem_rd_data;
    logic [3:0] wreg_rd_data;
    logic [10:0] stack_top;
    logic [3:0] acc_reg;
    logic carry_flag;
    logic zero_flag;
    logic [10:0] pc_reg;
    logic mem_we;
    logic [6:0] mem_addr;
    logic [3:0] mem_wr_data;
    logic wreg_we;
    logic [3:0] wreg_addr;
    logic [3:0] wreg_wr_data;
    logic stack_pop;
    int n_fail;
    int checked;

    nor_exec i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .exec_en(exec_en), .opcode(opcode),
        .mem_rd_data(mem_rd_data), .wreg_rd_data(wreg_rd_data), .stack_top(stack_top),
        .acc_reg(acc_reg), .carry_flag(carry_flag), .zero_flag(zero_flag), .pc_reg(pc_reg),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wr_data(mem_wr_data), .wreg_we(wreg_we),
        .wreg_addr(wreg_addr), .wreg_wr_data(wreg_wr_data), .stack_pop(stack_pop));

    // ============================================================
    // helpers
    task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // drive one op, return just after the edge that takes it
    task automatic issue(input logic [15:0] op, input logic [3:0] m, input logic [3:0] w,
        input logic [10:0] s);
        opcode = op;
        mem_rd_data = m;
        wreg_rd_data = w;
        stack_top = s;
        exec_en = 1'b1;
        @(posedge sys_clk);
        #1;
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ============================================================
    // scenarios
    task automatic t_or_acc();
        issue({nor_pkg::OP_OR_TO_ACC_IMM, 1'b0, 4'hA, 4'h3}, 4'h0, 4'h5, 11'h000);
        chk("acc", 11'(4'hF), 11'(acc_reg));
        chk("zero", 11'h000, 11'(zero_flag));
        chk("stores", 11'h000, 11'({mem_we, wreg_we}));
        issue({nor_pkg::OP_OR_TO_ACC_IMM, 1'b0, 4'h0, 4'h3}, 4'hF, 4'h0, 11'h000);
        chk("zero", 11'h001, 11'(zero_flag));
    endtask

    task automatic t_or_mem();
        issue({nor_pkg::OP_OR_TO_ACC_IMM, 1'b0, 4'h2, 4'h1}, 4'h0, 4'h0, 11'h000);
        issue({nor_pkg::OP_OR_STORE_MEM, 7'h5A}, 4'h4, 4'h0, 11'h000);
        chk("acc", 11'(4'h6), 11'(acc_reg));
        chk("mem", 11'({1'b1, 7'h5A}), 11'({mem_we, mem_addr}));
        chk("mem_data", 11'(4'h6), 11'(mem_wr_data));
    endtask

    task automatic t_or_wreg();
        issue({nor_pkg::OP_OR_STORE_IMM, 4'h1, 4'h7}, 4'h0, 4'h2, 11'h000);
        chk("acc", 11'(4'h3), 11'(acc_reg));
        chk("wreg", 11'({1'b1, 4'h7, 4'h3}), 11'({wreg_we, wreg_addr, wreg_wr_data}));
        chk("mem_we", 11'h000, 11'(mem_we));
        issue({nor_pkg::OP_OR_STORE_IMM, 4'h8, 4'hC}, 4'h0, 4'h4, 11'h000);
        chk("wreg", 11'({1'b1, 4'hC, 4'hC}), 11'({wreg_we, wreg_addr, wreg_wr_data}));
        chk("acc_zero", 11'({4'hC, 1'b0}), 11'({acc_reg, zero_flag}));
    endtask

    task automatic rot(input logic [8:0] pre, input logic [3:0] m, input logic [3:0] e,
        input logic c);
        issue({pre, 7'h11}, m, 4'h0, 11'h000);
        chk("rot_acc", 11'(e), 11'(acc_reg));
        chk("rot_mem", 11'({1'b1, e}), 11'({mem_we, mem_wr_data}));
        chk("rot_flags", 11'({c, e == 4'h0}), 11'({carry_flag, zero_flag}));
    endtask

    task automatic t_return();
        issue({nor_pkg::OP_SUB_RETURN, 3'h0}, 4'h0, 4'h0, 11'h5A3);
        chk("pc", 11'h5A3, pc_reg);
        chk("pop", 11'h001, 11'(stack_pop));
        chk("ret_state", 11'h001, 11'({acc_reg, carry_flag, zero_flag}));
        exec_en = 1'b0;
        @(posedge sys_clk);
        #1;
        chk("pop_end", 11'h000, 11'(stack_pop));
        chk("pc_hold", 11'h5A3, pc_reg);
    endtask

    // idle cycle, undecoded word, then reset in mid-run
    task automatic t_ignored();
        opcode = {nor_pkg::OP_ROT_LEFT, 7'h22};
        mem_rd_data = 4'hF;
        exec_en = 1'h0;
        @(posedge sys_clk);
        #1;
        chk("idle", 11'h001, 11'({mem_we, acc_reg, carry_flag, zero_flag}));
        issue(16'hFFFF, 4'hF, 4'hF, 11'h7FF);
        chk("undec_strobes", 11'h000, 11'({mem_we, wreg_we, stack_pop}));
        chk("undec_state", 11'h001, 11'({acc_reg, carry_flag, zero_flag}));
        chk("undec_pc", 11'h5A3, pc_reg);
        issue({nor_pkg::OP_OR_TO_ACC_IMM, 1'h0, 4'h5, 4'h0}, 4'h0, 4'h0, 11'h000);
        chk("pre_rst", 11'(4'h5), 11'(acc_reg));
        exec_en = 1'h0;
        rst_n = 1'h0;
        @(posedge sys_clk);
        #1;
        chk("mid_rst", 11'h000, 11'({acc_reg, carry_flag, zero_flag, mem_we}));
        chk("mid_rst_pc", 11'h000, pc_reg);
        rst_n = 1'h1;
        issue({nor_pkg::OP_ROT_RIGHT, 7'h03}, 4'h2, 4'h0, 11'h000);
        chk("post_rst", 11'h004, 11'({acc_reg, carry_flag, zero_flag}));
    endtask

    // ============================================================
    // clock, reset, sequence
    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    initial
    begin
        n_fail = 0;
        checked = 0;
        rst_n = 1'b0;
        exec_en = 1'b0;
        opcode = 16'h0000;
        mem_rd_data = 4'h0;
        wreg_rd_data = 4'h0;
        stack_top = 11'h000;
        repeat (8) @(posedge sys_clk);
        #1;
        rst_n = 1'b1;
        chk("rst", 11'h000, 11'({acc_reg, carry_flag, pc_reg == 11'h000}) ^ 11'h001);
        t_or_acc();
        t_or_mem();
        t_or_wreg();
        rot(nor_pkg::OP_ROT_LEFT, 4'h9, 4'h2, 1'b1);
        rot(nor_pkg::OP_ROT_RIGHT, 4'h1, 4'h8, 1'b1);
        rot(nor_pkg::OP_ROT_RIGHT, 4'h0, 4'h8, 1'b0);
        rot(nor_pkg::OP_ROT_LEFT, 4'h0, 4'h0, 1'b0);
        t_return();
        t_ignored();
        tally_and_finish();
    end
endmodule

// ---- nor_pkg.sv ----
package nor_pkg;
    // ============================================================
    // widths
    localparam int DATA_W = 4;
    localparam int ADDR_W = 7;
    localparam int WR_W = 4;
    localparam int PC_W = 11;
    localparam int OP_W = 16;
    // ============================================================
    // opcode prefixes, most significant bits of the 16-bit word
    localparam logic [6:0] OP_OR_TO_ACC_IMM = 7'h1E;
    localparam logic [8:0] OP_OR_STORE_MEM = 9'h076;
    // eight-bit prefix so that all four immediate bits stay free
    localparam logic [7:0] OP_OR_STORE_IMM = 8'h3F;
    localparam logic [8:0] OP_ROT_LEFT = 9'h099;
    localparam logic [8:0] OP_ROT_RIGHT = 9'h09B;
    localparam logic [12:0] OP_SUB_RETURN = 13'h0040;
    // ============================================================
    // reset values and cycles per op
    localparam logic [DATA_W-1:0] ACC_RST = 4'h0;
    localparam logic [PC_W-1:0] PC_RST = 11'h000;
    localparam int CYCLES_PER_OP = 1;

    typedef enum logic [2:0] {
        NOR_OP_NONE,
        NOR_OP_OR_ACC,
        NOR_OP_OR_MEM,
        NOR_OP_OR_WREG,
        NOR_OP_ROT_L,
        NOR_OP_ROT_R,
        NOR_OP_RET
    } nor_op_t;
endpackage
